// ===== hw/sfe_fifo.sv
// eight entry sixteen bit frame queue
`timescale 1ns/1ps
`default_nettype none
module sfe_fifo (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	sfe_fifo_if.store f
);
	import sfe_pkg::*;
	typedef struct packed {
		sfe_frame_t [FIFO_DEPTH-1:0] mem; // R23
		sfe_ptr_t rptr;
		sfe_ptr_t wptr;
		sfe_cnt_t count;
	} sfe_fifo_st_t;
	sfe_fifo_st_t st_r;
	sfe_fifo_st_t st_nxt;
	logic do_push;
	logic do_pop;
	always_comb begin
		st_nxt = st_r;
		do_push = f.push && (st_r.count != CNT_FULL);
		do_pop = f.pop && (st_r.count != CNT_RST);
		if (f.clear) begin
			st_nxt.rptr = PTR_RST;
			st_nxt.wptr = PTR_RST;
			st_nxt.count = CNT_RST;
		end else begin
			if (do_push) begin
				st_nxt.mem[st_r.wptr] = f.push_data;
				st_nxt.wptr = st_r.wptr + 3'h1;
			end
			if (do_pop) begin
				st_nxt.rptr = st_r.rptr + 3'h1;
			end
			case ({do_push, do_pop})
				2'b10: st_nxt.count = st_r.count + 4'h1;
				2'b01: st_nxt.count = st_r.count - 4'h1;
				default: st_nxt.count = st_r.count;
			endcase
		end
	end
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign f.full = (st_r.count == CNT_FULL);
	assign f.empty = (st_r.count == CNT_RST);
	assign f.count = st_r.count;
	assign f.rptr = st_r.rptr;
	assign f.wptr = st_r.wptr;
	assign f.head = st_r.mem[st_r.rptr];
endmodule
`default_nettype wire

// ===== hw/sfe_fifo_if.sv
// carrier between the front end and one frame queue
`timescale 1ns/1ps
`default_nettype none
interface sfe_fifo_if;
	import sfe_pkg::*;
	logic push;
	sfe_frame_t push_data;
	logic pop;
	logic clear;
	logic full;
	logic empty;
	sfe_cnt_t count;
	sfe_ptr_t rptr;
	sfe_ptr_t wptr;
	sfe_frame_t head;
	modport store(input push, push_data, pop, clear,
		output full, empty, count, rptr, wptr, head);
	modport user(output push, push_data, pop, clear,
		input full, empty, count, rptr, wptr, head);
endinterface
`default_nettype wire

// ===== hw/sfe_pkg.sv
// shared constants and types of the spi register and interrupt front end
package sfe_pkg;
	localparam int FIFO_DEPTH = 8;
	localparam logic [3:0] CNT_FULL = 4'h8;
	localparam logic [1:0] MODE_SPI = 2'h1;
	localparam logic [1:0] PROTO_STD = 2'h0;
	localparam logic [1:0] PROTO_TI = 2'h1;
	localparam logic [1:0] PROTO_NS = 2'h2;
	localparam logic [7:0] CMD_WRITE = 8'h01;
	localparam logic [7:0] CMD_READ = 8'h02;
	localparam int TXE_TRIG = 0;
	localparam int TXE_NOT_FULL = 1;
	localparam int TXE_EMPTY = 2;
	localparam int TXE_OVF = 3;
	localparam int TXE_UDF = 4;
	localparam int RXE_TRIG = 0;
	localparam int RXE_FULL = 1;
	localparam int RXE_NOT_EMPTY = 2;
	localparam int RXE_OVF = 3;
	localparam int RXE_UDF = 4;
	localparam int SPE_MDONE = 0;
	localparam int SPE_BUS_ERR = 1;
	localparam int SPE_AM_STOP = 2;
	localparam int SPE_AM_WSTOP = 3;
	localparam int SPE_WAKE = 4;
	localparam int SPE_STOP = 5;
	localparam int SPE_WSTOP = 6;
	localparam int SPE_RSTOP = 7;
	localparam logic [15:0] FRAME_RST = 16'h0000;
	localparam logic [4:0] EV5_RST = 5'h00;
	localparam logic [7:0] EV8_RST = 8'h00;
	localparam logic [3:0] CNT_RST = 4'h0;
	localparam logic [2:0] PTR_RST = 3'h0;
	typedef logic [15:0] sfe_frame_t;
	typedef logic [3:0] sfe_width_t;
	typedef logic [3:0] sfe_cnt_t;
	typedef logic [2:0] sfe_ptr_t;
	typedef logic [4:0] sfe_ev5_t;
	typedef logic [7:0] sfe_ev8_t;
	typedef enum logic {SFE_IDLE, SFE_FRAME} sfe_link_t;
	typedef struct packed {
		sfe_cnt_t count;
		sfe_ptr_t rptr;
		sfe_ptr_t wptr;
		logic valid;
	} sfe_qstat_t;
	localparam sfe_qstat_t QSTAT_RST = 11'h000;
endpackage

// ===== hw/sfe_sync.sv
// two stage synchroniser with one extra stage for edge finding
`timescale 1ns/1ps
`default_nettype none
module sfe_sync #(
	parameter int W = 3
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_now,
	output logic [W-1:0] o_prev
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
	} sfe_sync_st_t;
	sfe_sync_st_t st_r;
	sfe_sync_st_t st_nxt;
	always_comb begin
		st_nxt.s1 = i_async;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
	end
	// reset to ones: select idles high, so no false start at release
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_r <= '1;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign o_now = st_r.s2;
	assign o_prev = st_r.s3;
endmodule
`default_nettype wire

// ===== hw/sfe_top.sv
// spi control, status, queue access and interrupt front end
// How it works
// R01: all control and status fields fit within 32-bit registers
// R02: global enable, interface type and external clocking select the block; the code activates on i_enable and i_if_mode only
// R03: role, protocol, cpol/cpha submode and select pulse style are configurable
// R04: bus busy is reported while a transfer is under way
// R05: tx and rx each have frame width and bit order settings
// R06: each queue has trigger level, clear with shift register, and freeze
// R07: a software push appends a frame to the tx queue tail
// R08: a software pop returns the oldest rx frame and removes it
// R09: peek returns the oldest rx frame without removing it
// R10: queue status gives count, read and write pointers and valid flag
// R11: an address match value and mask are held
// R12: tx interrupt is the or of enabled tx sources
// R13: rx interrupt is the or of enabled rx sources
// R14: master done and unexpected deselect bus error events
// R15: slave deselect after addressed-memory transfer, and after such a write
// R16: tx trigger while tx queue holds fewer than the trigger level
// R17: tx not full, empty, overflow and underflow events
// R18: rx full, not empty, overflow and underflow events
// R19: select assertion raises wake request when externally clocked
// R20: externally clocked stop events for any, write and read transfers
// R21: the interrupt outputs stay inside the chip, never on a pin
// R22: frozen queue ignores hardware reads and writes, pointers hold
// R23: tx and rx queues are eight entries of sixteen bits each
// R24: every interrupt source has its own mask bit before the or
`timescale 1ns/1ps
`default_nettype none
module sfe_top (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic i_enable,
	input wire logic [1:0] i_if_mode,
	input wire logic i_ext_clk,
	input wire logic i_master,
	input wire logic [1:0] i_protocol,
	input wire logic i_cpol,
	input wire logic i_cpha,
	input wire logic i_select_precede,
	input wire logic i_am_mode,
	input wire sfe_pkg::sfe_width_t i_tx_width,
	input wire logic i_tx_msb_first,
	input wire sfe_pkg::sfe_width_t i_rx_width,
	input wire logic i_rx_msb_first,
	input wire sfe_pkg::sfe_cnt_t i_tx_trig,
	input wire logic i_tx_clear,
	input wire logic i_tx_freeze,
	input wire sfe_pkg::sfe_cnt_t i_rx_trig,
	input wire logic i_rx_clear,
	input wire logic i_rx_freeze,
	input wire logic i_tx_push,
	input wire sfe_pkg::sfe_frame_t i_tx_data,
	input wire logic i_rx_pop,
	input wire logic [7:0] i_match_addr,
	input wire logic [7:0] i_match_mask,
	input wire sfe_pkg::sfe_ev5_t i_tx_mask,
	input wire sfe_pkg::sfe_ev5_t i_rx_mask,
	input wire sfe_pkg::sfe_ev8_t i_spi_mask,
	input wire sfe_pkg::sfe_ev5_t i_tx_evt_clr,
	input wire sfe_pkg::sfe_ev5_t i_rx_evt_clr,
	input wire sfe_pkg::sfe_ev8_t i_spi_evt_clr,
	input wire logic i_sclk,
	input wire logic i_ss_b,
	input wire logic i_mosi,
	output logic o_miso,
	output logic o_miso_oe_b,
	output logic o_bus_busy,
	output sfe_pkg::sfe_qstat_t o_tx_status,
	output sfe_pkg::sfe_qstat_t o_rx_status,
	output sfe_pkg::sfe_frame_t o_rx_pop_data,
	output sfe_pkg::sfe_frame_t o_rx_peek_data,
	output logic [7:0] o_match_addr,
	output logic [7:0] o_match_mask,
	output logic o_match_hit,
	output sfe_pkg::sfe_ev5_t o_tx_events,
	output sfe_pkg::sfe_ev5_t o_rx_events,
	output sfe_pkg::sfe_ev8_t o_spi_events,
	output logic o_tx_irq,
	output logic o_rx_irq,
	output logic o_spi_irq
);
	import sfe_pkg::*;
	typedef struct packed {
		sfe_link_t link;
		sfe_cnt_t cnt;
		sfe_frame_t rx_sh;
		sfe_frame_t tx_sh;
		logic [7:0] cmd;
		logic got;
		logic miso;
		logic oe_b;
		logic busy;
		sfe_qstat_t tx_stat;
		sfe_qstat_t rx_stat;
		sfe_frame_t pop_data;
		sfe_frame_t peek_data;
		logic [7:0] m_addr;
		logic [7:0] m_mask;
		logic hit;
		sfe_ev5_t tx_stk;
		sfe_ev5_t rx_stk;
		sfe_ev8_t spi_stk;
		sfe_ev5_t tx_src;
		sfe_ev5_t rx_src;
		sfe_ev8_t spi_src;
		logic tx_irq;
		logic rx_irq;
		logic spi_irq;
	} sfe_top_st_t;
	sfe_top_st_t st_r;
	sfe_top_st_t st_nxt;
	sfe_fifo_if tq ();
	sfe_fifo_if rq ();
	logic [2:0] pin_now;
	logic [2:0] pin_prev;
	logic act;
	logic eff_cpol;
	logic eff_cpha;
	logic sel;
	logic sel_prev;
	logic rise;
	logic fall;
	logic samp;
	logic shft;
	logic start;
	logic stop;
	logic ld;
	sfe_frame_t frame;
	sfe_ev5_t tx_pulse;
	sfe_ev5_t rx_pulse;
	sfe_ev8_t spi_pulse;
	sfe_ev5_t tx_lvl;
	sfe_ev5_t rx_lvl;
	function automatic sfe_width_t bit_idx(input logic msb,
		input sfe_width_t w, input sfe_cnt_t c);
		return msb ? (w - c) : c;
	endfunction
	sfe_fifo u_tx_fifo (
		.i_ref_clk(i_ref_clk),
		.i_rst_b(i_rst_b),
		.f(tq.store)
	);
	sfe_fifo u_rx_fifo (
		.i_ref_clk(i_ref_clk),
		.i_rst_b(i_rst_b),
		.f(rq.store)
	);
	sfe_sync #(.W(3)) u_pin_sync (
		.i_ref_clk(i_ref_clk),
		.i_rst_b(i_rst_b),
		.i_async({i_sclk, i_ss_b, i_mosi}),
		.o_now(pin_now),
		.o_prev(pin_prev)
	);
	always_comb begin
		st_nxt = st_r;
		tx_pulse = EV5_RST;
		rx_pulse = EV5_RST;
		spi_pulse = EV8_RST;
		ld = 1'b0;
		frame = FRAME_RST;
		// disabling wipes queues and link state, as re-enable must
		act = i_enable && (i_if_mode == MODE_SPI); // R02
		// ti only runs mode 1 and ns only mode 0
		eff_cpol = (i_protocol == PROTO_STD) ? i_cpol : 1'b0; // R03
		eff_cpha = (i_protocol == PROTO_TI) ? 1'b1 :
			(i_protocol == PROTO_NS) ? 1'b0 : i_cpha; // R03
		rise = pin_now[2] && !pin_prev[2];
		fall = !pin_now[2] && pin_prev[2];
		samp = (eff_cpol == eff_cpha) ? rise : fall;
		shft = (eff_cpol == eff_cpha) ? fall : rise;
		// ti select is an active high pulse, others active low
		sel = (i_protocol == PROTO_TI) ? pin_now[1] : !pin_now[1];
		sel_prev = (i_protocol == PROTO_TI) ? pin_prev[1] : !pin_prev[1];
		if (i_protocol == PROTO_TI) begin
			start = i_select_precede ? (!sel && sel_prev) :
				(sel && !sel_prev); // R03
			stop = 1'b0;
		end else begin
			start = sel && !sel_prev;
			stop = !sel && sel_prev;
		end
		tq.clear = !act || i_tx_clear; // R06
		rq.clear = !act || i_rx_clear; // R06
		tq.push = act && i_tx_push && !tq.full; // R07
		tq.push_data = i_tx_data;
		tx_pulse[TXE_OVF] = act && i_tx_push && tq.full; // R17
		rq.pop = act && i_rx_pop && !rq.empty; // R08
		rx_pulse[RXE_UDF] = act && i_rx_pop && rq.empty; // R18
		if (rq.pop) begin
			st_nxt.pop_data = rq.head; // R08
		end
		st_nxt.peek_data = rq.head; // R09
		tq.pop = 1'b0;
		rq.push = 1'b0;
		rq.push_data = FRAME_RST;
		st_nxt.m_addr = i_match_addr; // R11
		st_nxt.m_mask = i_match_mask; // R11
		if (!act) begin
			st_nxt.link = SFE_IDLE;
			st_nxt.cnt = CNT_RST;
			st_nxt.rx_sh = FRAME_RST;
			st_nxt.tx_sh = FRAME_RST;
			st_nxt.got = 1'b0;
			st_nxt.miso = 1'b0;
		end else if (start) begin
			st_nxt.link = SFE_FRAME;
			st_nxt.cnt = CNT_RST;
			st_nxt.rx_sh = FRAME_RST;
			st_nxt.got = 1'b0;
			ld = 1'b1;
			spi_pulse[SPE_WAKE] = i_ext_clk; // R19
		end else if (stop) begin
			st_nxt.link = SFE_IDLE;
			// select gone with bits still pending in the frame
			spi_pulse[SPE_BUS_ERR] = (st_r.cnt != CNT_RST); // R14
			spi_pulse[SPE_MDONE] = i_master && st_r.got &&
				(st_r.cnt == CNT_RST); // R14
			spi_pulse[SPE_AM_STOP] = i_am_mode && st_r.got; // R15
			spi_pulse[SPE_AM_WSTOP] = i_am_mode && st_r.got &&
				(st_r.cmd == CMD_WRITE); // R15
			spi_pulse[SPE_STOP] = i_ext_clk; // R20
			spi_pulse[SPE_WSTOP] = i_ext_clk && st_r.got &&
				(st_r.cmd == CMD_WRITE); // R20
			spi_pulse[SPE_RSTOP] = i_ext_clk && st_r.got &&
				(st_r.cmd == CMD_READ); // R20
		end else if (st_r.link == SFE_FRAME) begin
			if (samp) begin
				st_nxt.rx_sh[bit_idx(i_rx_msb_first, i_rx_width,
					st_r.cnt)] = pin_now[0]; // R05
				if (st_r.cnt == i_rx_width) begin
					frame = st_nxt.rx_sh;
					st_nxt.rx_sh = FRAME_RST;
					st_nxt.cnt = CNT_RST;
					if (!i_rx_freeze) begin // R22
						rq.push = !rq.full;
						rq.push_data = frame;
						rx_pulse[RXE_OVF] = rq.full; // R18
					end
					if (!st_r.got) begin
						st_nxt.cmd = frame[7:0];
						st_nxt.hit = ((frame[7:0] ^ st_r.m_addr) &
							st_r.m_mask) == 8'h00; // R11
					end
					st_nxt.got = 1'b1;
					// a ti frame needs its own select pulse
					if (i_protocol == PROTO_TI) begin
						st_nxt.link = SFE_IDLE;
					end else begin
						ld = 1'b1;
					end
				end else begin
					st_nxt.cnt = st_r.cnt + 4'h1;
				end
			end
			if (shft) begin
				st_nxt.miso = st_r.tx_sh[bit_idx(i_tx_msb_first,
					i_tx_width, st_r.cnt)]; // R05
			end
		end
		if (ld) begin
			// frozen: keep the old shift word, queue untouched
			if (!i_tx_freeze) begin // R22
				if (tq.empty) begin
					tx_pulse[TXE_UDF] = 1'b1; // R17
					st_nxt.tx_sh = FRAME_RST;
				end else begin
					tq.pop = 1'b1;
					st_nxt.tx_sh = tq.head;
				end
			end
			if (start && !eff_cpha) begin
				st_nxt.miso = st_nxt.tx_sh[bit_idx(i_tx_msb_first,
					i_tx_width, CNT_RST)];
			end
		end
		if (i_tx_clear) begin
			st_nxt.tx_sh = FRAME_RST; // R06
		end
		if (i_rx_clear) begin
			st_nxt.rx_sh = FRAME_RST; // R06
			st_nxt.cnt = CNT_RST;
		end
		st_nxt.busy = act && (st_nxt.link == SFE_FRAME); // R04
		st_nxt.oe_b = !(act && !i_master && sel);
		st_nxt.tx_stat = {tq.count, tq.rptr, tq.wptr, !tq.empty}; // R10 R01
		st_nxt.rx_stat = {rq.count, rq.rptr, rq.wptr, !rq.empty}; // R10
		tx_lvl = EV5_RST;
		tx_lvl[TXE_TRIG] = tq.count < i_tx_trig; // R16
		tx_lvl[TXE_NOT_FULL] = !tq.full; // R17
		tx_lvl[TXE_EMPTY] = tq.empty; // R17
		rx_lvl = EV5_RST;
		rx_lvl[RXE_TRIG] = rq.count > i_rx_trig;
		rx_lvl[RXE_FULL] = rq.full; // R18
		rx_lvl[RXE_NOT_EMPTY] = !rq.empty; // R18
		// set wins over a clear in the same cycle
		st_nxt.tx_stk = (st_r.tx_stk & ~i_tx_evt_clr) | tx_pulse;
		st_nxt.rx_stk = (st_r.rx_stk & ~i_rx_evt_clr) | rx_pulse;
		st_nxt.spi_stk = (st_r.spi_stk & ~i_spi_evt_clr) | spi_pulse;
		st_nxt.tx_src = st_nxt.tx_stk | tx_lvl;
		st_nxt.rx_src = st_nxt.rx_stk | rx_lvl;
		st_nxt.spi_src = st_nxt.spi_stk;
		st_nxt.tx_irq = |(st_nxt.tx_src & i_tx_mask); // R12 R24
		st_nxt.rx_irq = |(st_nxt.rx_src & i_rx_mask); // R13 R24
		st_nxt.spi_irq = |(st_nxt.spi_src & i_spi_mask); // R24
	end
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_r <= '0;
			st_r.oe_b <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign o_miso = st_r.miso;
	assign o_miso_oe_b = st_r.oe_b;
	assign o_bus_busy = st_r.busy;
	assign o_tx_status = st_r.tx_stat;
	assign o_rx_status = st_r.rx_stat;
	assign o_rx_pop_data = st_r.pop_data;
	assign o_rx_peek_data = st_r.peek_data;
	assign o_match_addr = st_r.m_addr;
	assign o_match_mask = st_r.m_mask;
	assign o_match_hit = st_r.hit;
	assign o_tx_events = st_r.tx_src;
	assign o_rx_events = st_r.rx_src;
	assign o_spi_events = st_r.spi_src;
	// interrupt lines are for the on-chip controller only
	assign o_tx_irq = st_r.tx_irq; // R21
	assign o_rx_irq = st_r.rx_irq; // R21
	assign o_spi_irq = st_r.spi_irq; // R21
endmodule
`default_nettype wire

// ===== testbench/sfe_spi_master.sv
// behavioural spi master driving the serial pins
`timescale 1ns/1ps
`default_nettype none
module sfe_spi_master (
	output logic o_sclk,
	output logic o_ss_b,
	output logic o_mosi,
	input wire logic i_miso
);
	initial begin
		o_sclk = 1'b0;
		o_ss_b = 1'b1;
		o_mosi = 1'b0;
	end
	// stop below n deselects early; sclk stands still outside frames
	task automatic xfer(input logic [15:0] d, input int n, input logic pol,
		input logic pha, input logic msb, input int stop,
		output logic [15:0] q);
		logic b;
		q = 16'h0000;
		o_sclk = pol;
		o_ss_b = 1'b0;
		#160;
		for (int i = 0; i < stop; i++) begin
			b = msb ? d[n-1-i] : d[i];
			if (pha) o_sclk = ~pol;
			o_mosi = b;
			#80;
			o_sclk = pha ? pol : ~pol;
			q = {q[14:0], i_miso};
			#80;
			if (!pha) o_sclk = pol;
		end
		#160;
		o_ss_b = 1'b1;
		// released line: no stale value left behind
		o_mosi = ~o_mosi;
	endtask
endmodule
`default_nettype wire

// ===== testbench/sfe_top_properties.sv
// port level assertions for the spi front end
`timescale 1ns/1ps
`default_nettype none
module sfe_top_properties (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic i_enable,
	input wire logic [1:0] i_if_mode,
	input wire logic i_ext_clk,
	input wire sfe_pkg::sfe_cnt_t i_tx_trig,
	input wire logic i_tx_push,
	input wire logic i_rx_pop,
	input wire sfe_pkg::sfe_ev5_t i_tx_mask,
	input wire sfe_pkg::sfe_ev8_t i_spi_mask,
	input wire sfe_pkg::sfe_ev5_t i_tx_evt_clr,
	input wire sfe_pkg::sfe_ev5_t i_rx_evt_clr,
	input wire sfe_pkg::sfe_ev8_t i_spi_evt_clr,
	input wire logic i_ss_b,
	input wire logic o_bus_busy,
	input wire sfe_pkg::sfe_qstat_t o_tx_status,
	input wire sfe_pkg::sfe_qstat_t o_rx_status,
	input wire sfe_pkg::sfe_frame_t o_rx_pop_data,
	input wire sfe_pkg::sfe_frame_t o_rx_peek_data,
	input wire sfe_pkg::sfe_ev5_t o_tx_events,
	input wire sfe_pkg::sfe_ev5_t o_rx_events,
	input wire sfe_pkg::sfe_ev8_t o_spi_events,
	input wire logic o_tx_irq,
	input wire logic o_spi_irq
);
	import sfe_pkg::*;
	logic act;
	assign act = i_enable && (i_if_mode == MODE_SPI);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);
	a_tx_irq_or: assert property ($stable(i_tx_mask) |->
		o_tx_irq == |(o_tx_events & i_tx_mask)) else $error("tx irq");
	a_spi_irq_or: assert property ($stable(i_spi_mask) |->
		o_spi_irq == |(o_spi_events & i_spi_mask)) else $error("spi irq");
	// status and level events are registered from the same queue sample
	a_tx_empty_flag: assert property ($past(i_rst_b, 2) |->
		(o_tx_status.count == CNT_RST) == o_tx_events[TXE_EMPTY])
		else $error("tx empty");
	a_rx_full_flag: assert property ($past(i_rst_b, 2) |->
		(o_rx_status.count == CNT_FULL) == o_rx_events[RXE_FULL])
		else $error("rx full");
	a_tx_trig_level: assert property ($past(i_rst_b, 2) &&
		$stable(i_tx_trig) |-> o_tx_events[TXE_TRIG] ==
		(o_tx_status.count < i_tx_trig)) else $error("tx trig");
	a_tx_ovf_set: assert property (i_tx_push && act && i_ss_b &&
		!o_bus_busy && o_tx_status.count == CNT_FULL && !i_tx_evt_clr[3]
		|=> o_tx_events[TXE_OVF]) else $error("tx overflow");
	a_rx_udf_set: assert property (i_rx_pop && act && !o_bus_busy &&
		!$past(o_bus_busy) && o_rx_status.count == CNT_RST &&
		!i_rx_evt_clr[4] |=> o_rx_events[RXE_UDF]) else $error("rx udf");
	a_pop_is_head: assert property (i_rx_pop && !$past(i_rx_pop) &&
		act && !o_bus_busy && o_rx_status.count > 4'h1 |=>
		o_rx_pop_data == $past(o_rx_peek_data)) else $error("pop data");
	a_wake_on_sel: assert property ($fell(i_ss_b) && act && i_ext_clk &&
		i_spi_evt_clr == EV8_RST |-> ##[2:6] o_spi_events[SPE_WAKE])
		else $error("wake");
	a_busy_on_sel: assert property ($fell(i_ss_b) && act |->
		##[2:6] o_bus_busy) else $error("busy");
	c_tx_ovf: cover property (o_tx_events[TXE_OVF]);
	c_bus_err: cover property (o_spi_events[SPE_BUS_ERR]);
	c_rx_full: cover property (o_rx_events[RXE_FULL]);
endmodule
bind sfe_top sfe_top_properties u_props (.*);
`default_nettype wire

// ===== testbench/tb_sfe_top.sv
// self-checking bench for the spi front end
`timescale 1ns/1ps
`default_nettype none
module tb_sfe_top;
	import sfe_pkg::*;
	logic i_ref_clk, i_rst_b, i_enable, i_ext_clk, i_master, i_cpol, i_cpha;
	logic i_select_precede, i_am_mode, i_tx_msb_first, i_rx_msb_first;
	logic i_tx_clear, i_tx_freeze, i_rx_clear, i_rx_freeze, i_tx_push;
	logic i_rx_pop, o_miso, o_miso_oe_b, o_bus_busy, o_match_hit;
	logic o_tx_irq, o_rx_irq, o_spi_irq;
	logic [1:0] i_if_mode, i_protocol;
	logic [7:0] i_match_addr, i_match_mask, o_match_addr, o_match_mask, e;
	sfe_width_t i_tx_width, i_rx_width;
	sfe_cnt_t i_tx_trig, i_rx_trig;
	sfe_frame_t i_tx_data, o_rx_pop_data, o_rx_peek_data, q;
	sfe_ev5_t i_tx_mask, i_rx_mask, i_tx_evt_clr, i_rx_evt_clr;
	sfe_ev5_t o_tx_events, o_rx_events;
	sfe_ev8_t i_spi_mask, i_spi_evt_clr, o_spi_events;
	sfe_qstat_t o_tx_status, o_rx_status;
	wire logic i_sclk, i_ss_b, i_mosi;
	logic [7:0] fr [4] = '{8'h01, 8'h02, 8'h35, 8'hC3};
	int err_count = 0;
	int checks_done = 0;
	int cyc = 0;
	sfe_top DUT (.*);
	sfe_spi_master MST (.o_sclk(i_sclk), .o_ss_b(i_ss_b), .o_mosi(i_mosi),
		.i_miso(o_miso));
	initial begin
		i_ref_clk = 1'b0;
		forever #4 i_ref_clk = ~i_ref_clk;
	end
	task test_done;
		if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// ceiling sits well above the roughly 3600 cycles the run needs
	always @(posedge i_ref_clk) begin
		cyc++;
		if (cyc == 30000) begin
			err_count++;
			test_done;
		end
	end
	task chk(input logic [15:0] g, input logic [15:0] x, input string m);
		checks_done++;
		if (g !== x) begin
			err_count++;
			$display("mismatch %0t %s got %h exp %h", $time, m, g, x);
		end
	endtask
	task wt(input int n);
		repeat (n) @(negedge i_ref_clk);
	endtask
	task push(input sfe_frame_t d);
		i_tx_push = 1'b1;
		i_tx_data = d;
		wt(1);
		i_tx_push = 1'b0;
		wt(1);
	endtask
	task pop;
		i_rx_pop = 1'b1;
		wt(1);
		i_rx_pop = 1'b0;
		q = o_rx_pop_data;
		wt(1);
	endtask
	task clr_ev;
		{i_tx_evt_clr, i_rx_evt_clr, i_spi_evt_clr} = '1;
		wt(1);
		{i_tx_evt_clr, i_rx_evt_clr, i_spi_evt_clr} = '0;
		wt(1);
	endtask
	task sx(input sfe_frame_t d, input int n, input logic msb, input int s);
		MST.xfer(d, n, i_cpol, i_cpha, msb, s, q);
		wt(8);
	endtask
	initial begin
		{i_rst_b, i_master, i_cpol, i_cpha, i_select_precede} = '0;
		{i_tx_clear, i_tx_freeze, i_rx_clear, i_rx_freeze, i_tx_push} = '0;
		{i_rx_pop, i_protocol, i_rx_trig, i_tx_data, i_tx_mask} = '0;
		{i_rx_mask, i_spi_mask, i_tx_evt_clr, i_rx_evt_clr} = '0;
		i_spi_evt_clr = '0;
		{i_enable, i_ext_clk, i_am_mode, i_tx_msb_first, i_rx_msb_first} = '1;
		i_if_mode = MODE_SPI;
		{i_tx_width, i_rx_width} = {4'h7, 4'h7};
		{i_tx_trig, i_match_addr, i_match_mask} = {4'h4, 8'h3C, 8'hF0};
		wt(4);
		i_rst_b = 1'b1;
		wt(2);
		chk(o_tx_status, 16'h0000, "tx status reset");
		chk(o_tx_events, 16'h0007, "tx events reset");
		chk(o_miso_oe_b, 16'h0001, "miso released");
		chk({o_match_addr, o_match_mask}, 16'h3CF0, "match");
		for (int k = 0; k < 8; k++) push(16'h00A0 + 16'(k));
		chk(o_tx_status, 16'h0401, "tx full status");
		chk(o_tx_events, 16'h0000, "tx full events");
		push(16'h00EE);
		chk(o_tx_events, 16'h0008, "tx overflow");
		i_tx_mask = 5'h08;
		wt(2);
		chk(o_tx_irq, 16'h0001, "tx irq on");
		i_tx_mask = 5'h00;
		wt(2);
		chk(o_tx_irq, 16'h0000, "tx irq masked");
		clr_ev;
		for (int m = 0; m < 4; m++) begin
			{i_cpol, i_cpha} = 2'(m);
			wt(2);
			sx({8'h00, fr[m]}, 8, 1'b1, 8);
			// frame end preloads the next word: two pops per transfer
			chk(q[7:0], 8'hA0 + 8'(2 * m), "miso frame");
			chk(o_match_hit, (fr[m] & 8'hF0) == 8'h30, "hit");
			e = 8'h00;
			e[SPE_WAKE] = 1'b1;
			e[SPE_STOP] = 1'b1;
			e[SPE_AM_STOP] = 1'b1;
			e[SPE_WSTOP] = (fr[m] == CMD_WRITE);
			e[SPE_AM_WSTOP] = (fr[m] == CMD_WRITE);
			e[SPE_RSTOP] = (fr[m] == CMD_READ);
			chk(o_spi_events, e, "spi events");
			clr_ev;
		end
		chk(o_rx_status, 16'h0209, "rx status");
		chk(o_tx_status, 16'h0000, "tx status");
		wt(3);
		chk(o_rx_peek_data, 16'h0001, "peek");
		chk(o_rx_status, 16'h0209, "peek keeps");
		for (int m = 0; m < 4; m++) begin
			pop;
			chk(q, {8'h00, fr[m]}, "pop order");
		end
		pop;
		chk(o_rx_events[RXE_UDF], 16'h0001, "rx underflow");
		{i_tx_width, i_rx_width, i_tx_msb_first, i_rx_msb_first} = 10'h2EC;
		wt(2);
		sx(16'h0ABC, 12, 1'b0, 12);
		pop;
		chk(q, 16'h0ABC, "lsb first 12 bit");
		{i_tx_width, i_rx_width, i_tx_msb_first, i_rx_msb_first} = 10'h1DF;
		i_spi_mask = 8'h02;
		clr_ev;
		sx(16'h00FF, 8, 1'b1, 3);
		chk(o_spi_events[SPE_BUS_ERR], 16'h0001, "bus error");
		chk(o_spi_irq, 16'h0001, "spi irq");
		{i_rx_freeze, i_master} = 2'b11;
		sx(16'h0077, 8, 1'b1, 8);
		chk(o_rx_status, 16'h005A, "frozen rx");
		chk(o_spi_events[SPE_MDONE], 16'h0001, "master done");
		{i_rx_freeze, i_master} = 2'b00;
		clr_ev;
		for (int j = 0; j < 9; j++) sx(16'h0010 + 16'(j), 8, 1'b1, 8);
		chk(o_rx_events, 16'h000F, "rx full");
		chk(o_tx_events, 16'h0017, "tx underflow");
		i_rx_mask = 5'h02;
		wt(2);
		chk(o_rx_irq, 16'h0001, "rx irq");
		i_rx_clear = 1'b1;
		wt(1);
		i_rx_clear = 1'b0;
		wt(3);
		chk(o_rx_status, 16'h0000, "rx clear");
		i_protocol = PROTO_NS;
		{i_cpol, i_cpha} = 2'b10;
		wt(2);
		MST.xfer(16'h0081, 8, 1'b0, 1'b0, 1'b1, 8, q);
		wt(8);
		pop;
		chk(q, 16'h0081, "ns forces mode 0");
		push(16'h0055);
		chk(o_tx_status.count, 16'h0001, "active push");
		i_if_mode = 2'h2;
		push(16'h0066);
		wt(2);
		chk(o_tx_status.count, 16'h0000, "inactive mode");
		test_done;
	end
endmodule
`default_nettype wire
